/* shared/guest_virt_map.svh */
// Register offsets, field positions and reset values of the virtualization block
`ifndef GUEST_VIRT_MAP_SVH
`define GUEST_VIRT_MAP_SVH

`define TS_BIT            3
`define TPR_SHADOW_MSB    7
`define TPR_SHADOW_LSB    4
`define TPR_MSB           3
`define STAMP_MSR_INDEX   32'h0000_0010
`define STATUS_WORD_LOAD_INSTR_FIELD        32'h0000_000F
`define LOW16_MSB         15
`define HIGH_KEEP_LSB     16

`define OFF_CTRL          8'h00
`define OFF_CR0_MASK      8'h04
`define OFF_CR0_SHADOW    8'h08
`define OFF_CR4_MASK      8'h0C
`define OFF_CR4_SHADOW    8'h10
`define OFF_OFFSET_LO     8'h14
`define OFF_OFFSET_HI     8'h18
`define OFF_THRESHOLD     8'h1C
`define OFF_CR0_FIXED1    8'h20
`define OFF_CR0_ALLOWED1  8'h24
`define OFF_CR4_FIXED1    8'h28
`define OFF_CR4_ALLOWED1  8'h2C
`define OFF_CR0           8'h30
`define OFF_CR4           8'h34
`define OFF_TPR_BYTE      8'h38
`define OFF_STATUS        8'h3C
`define OFF_COUNT_LO      8'h40
`define OFF_COUNT_HI      8'h44
`define OFF_TPR           8'h48

`define ALLOWED1_RESET    32'hFFFF_FFFF
`define COUNT_STEP        64'h0000_0000_0000_0001

`endif

/* shared/guest_virt_pkg.sv */
// Types shared by the virtualization block and its decision logic
package guest_virt_pkg;

  typedef enum logic [3:0] {
    op_none, op_task_flag_clear_instr, op_interrupt_return_instr,
    op_status_word_load_instr, op_read_primary, op_read_extension,
    op_read_priority, op_write_primary, op_write_extension,
    op_write_priority, op_model_reg_read_instr, op_stamp_read_instr,
    op_status_word_store_instr
  } instr_op_type;

  typedef enum logic [1:0] {dest_16, dest_32, dest_64} dest_size_type;

  typedef struct packed {
    logic stamp_offset_en;
    logic stamp_read_exit;
    logic tpr_shadow_en;
    logic priority_load_exit;
    logic priority_store_exit;
    logic nmi_exit;
  } ctrl_type;

  typedef struct packed {
    ctrl_type    ctrl;
    logic [31:0] cr0_mask;
    logic [31:0] cr0_shadow;
    logic [31:0] cr4_mask;
    logic [31:0] cr4_shadow;
    logic [31:0] cr0_fixed1;
    logic [31:0] cr0_allowed1;
    logic [31:0] cr4_fixed1;
    logic [31:0] cr4_allowed1;
    logic [63:0] stamp_offset;
    logic [3:0]  threshold;
  } cfg_type;

  typedef struct packed {
    logic          valid;
    instr_op_type  op;
    logic [63:0]   operand;
    dest_size_type size;
    logic [31:0]   index;
  } req_type;

  typedef struct packed {
    logic [31:0] primary_control_reg;
    logic [31:0] extension_control_reg;
    logic [3:0]  task_priority_value;
    logic [7:0]  tpr_byte;
    logic [63:0] cycle_stamp_counter;
  } arch_type;

  typedef struct packed {
    logic        exit;
    logic        fault;
    logic        trap;
    logic        nmi_unblock;
    logic [63:0] result;
    arch_type    arch;
  } resp_type;

  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
    cfg_type     cfg;
    arch_type    arch;
    logic        nmi_blocked;
    logic        done;
    logic        exit;
    logic        fault;
    logic        trap;
    logic [63:0] result;
  } top_state_type;

endpackage : guest_virt_pkg

/* shared/decide_if.sv */
// Carrier between the top level and the instruction decision logic
`timescale 1ns/1ps
interface decide_if;
  import guest_virt_pkg::*;
  req_type  req;
  cfg_type  cfg;
  arch_type arch;
  resp_type resp;
  modport top     (output req, output cfg, output arch, input resp);
  modport decider (input req, input cfg, input arch, output resp);
endinterface : decide_if

/* src/instr_decider.sv */
// Combinational outcome of one guest instruction under the current controls
`timescale 1ns/1ps
`include "guest_virt_map.svh"
module instr_decider
  import guest_virt_pkg::*;
(
  // Request, configuration and state in; outcome out
  decide_if.decider dif
);

  function automatic logic [31:0] shadow_read(input logic [31:0] real_v,
      input logic [31:0] mask, input logic [31:0] shadow);
    shadow_read = (real_v & ~mask) | (shadow & mask);
  endfunction : shadow_read

  function automatic logic [31:0] keep_owned(input logic [31:0] old_v,
      input logic [31:0] mask, input logic [31:0] new_v);
    keep_owned = (old_v & mask) | (new_v & ~mask);
  endfunction : keep_owned

  function automatic logic unsupported(input logic [31:0] v,
      input logic [31:0] fixed1, input logic [31:0] allowed1);
    unsupported = |((~v & fixed1) | (v & ~allowed1));
  endfunction : unsupported

  logic [31:0] cr0_view;
  logic [31:0] cr4_view;
  logic [31:0] wr_val;
  logic [63:0] stamp_sum;
  cfg_type     c;
  arch_type    a;

  always_comb begin
    c = dif.cfg;
    a = dif.arch;
    cr0_view  = shadow_read(a.primary_control_reg, c.cr0_mask,
                            c.cr0_shadow);
    cr4_view  = shadow_read(a.extension_control_reg, c.cr4_mask,
                            c.cr4_shadow);
    stamp_sum = a.cycle_stamp_counter + c.stamp_offset;
    wr_val    = '0;
    dif.resp      = '0;
    dif.resp.arch = a;
    case (dif.req.op)
      op_task_flag_clear_instr: begin
        if (!c.cr0_mask[`TS_BIT]) begin
          if (c.cr0_fixed1[`TS_BIT]) begin
            dif.resp.fault = 1'b1;
          end else begin
            dif.resp.arch.primary_control_reg[`TS_BIT] = 1'b0;
          end
        end else if (c.cr0_shadow[`TS_BIT]) begin
          dif.resp.exit = 1'b1;
        end
        // Owned and shadow clear: completes, flag untouched
      end
      op_interrupt_return_instr: begin
        dif.resp.nmi_unblock = !c.ctrl.nmi_exit;
      end
      op_status_word_load_instr: begin
        // Exits when an owned bit would differ from what the guest sees
        if (|((dif.req.operand[31:0] ^ c.cr0_shadow) & c.cr0_mask &
              `STATUS_WORD_LOAD_INSTR_FIELD)) begin
          dif.resp.exit = 1'b1;
        end else begin
          wr_val = keep_owned(a.primary_control_reg, c.cr0_mask,
                   (a.primary_control_reg & ~`STATUS_WORD_LOAD_INSTR_FIELD) |
                   (dif.req.operand[31:0] & `STATUS_WORD_LOAD_INSTR_FIELD));
          if (unsupported(wr_val, c.cr0_fixed1, c.cr0_allowed1)) begin
            dif.resp.fault = 1'b1;
          end else begin
            dif.resp.arch.primary_control_reg = wr_val;
          end
        end
      end
      op_read_primary: dif.resp.result = {32'h0000_0000, cr0_view};
      op_read_extension: dif.resp.result = {32'h0000_0000, cr4_view};
      op_read_priority: begin
        if (c.ctrl.priority_store_exit) begin
          dif.resp.exit = 1'b1;
        end else if (c.ctrl.tpr_shadow_en) begin
          dif.resp.result = {60'h0, a.tpr_byte[`TPR_SHADOW_MSB:
                                               `TPR_SHADOW_LSB]};
        end else begin
          dif.resp.result = {60'h0, a.task_priority_value};
        end
      end
      op_write_primary: begin
        if (|((dif.req.operand[31:0] ^ c.cr0_shadow) & c.cr0_mask)) begin
          dif.resp.exit = 1'b1;
        end else begin
          wr_val = keep_owned(a.primary_control_reg, c.cr0_mask,
                              dif.req.operand[31:0]);
          if (unsupported(wr_val, c.cr0_fixed1, c.cr0_allowed1)) begin
            dif.resp.fault = 1'b1;
          end else begin
            dif.resp.arch.primary_control_reg = wr_val;
          end
        end
      end
      op_write_extension: begin
        if (|((dif.req.operand[31:0] ^ c.cr4_shadow) & c.cr4_mask)) begin
          dif.resp.exit = 1'b1;
        end else begin
          wr_val = keep_owned(a.extension_control_reg, c.cr4_mask,
                              dif.req.operand[31:0]);
          if (unsupported(wr_val, c.cr4_fixed1, c.cr4_allowed1)) begin
            dif.resp.fault = 1'b1;
          end else begin
            dif.resp.arch.extension_control_reg = wr_val;
          end
        end
      end
      op_write_priority: begin
        if (c.ctrl.priority_load_exit) begin
          dif.resp.exit = 1'b1;
        end else if (c.ctrl.tpr_shadow_en) begin
          dif.resp.arch.tpr_byte[`TPR_SHADOW_MSB:`TPR_SHADOW_LSB] =
            dif.req.operand[`TPR_MSB:0];
          dif.resp.trap = dif.req.operand[`TPR_MSB:0] < c.threshold;
        end else begin
          dif.resp.arch.task_priority_value =
            dif.req.operand[`TPR_MSB:0];
        end
      end
      op_model_reg_read_instr: begin
        if (dif.req.index != `STAMP_MSR_INDEX) begin
          dif.resp.exit = 1'b1;
        end else begin
          dif.resp.result = c.ctrl.stamp_offset_en ? stamp_sum
                          : a.cycle_stamp_counter;
        end
      end
      op_stamp_read_instr: begin
        if (c.ctrl.stamp_read_exit) begin
          dif.resp.exit = 1'b1;
        end else begin
          dif.resp.result = c.ctrl.stamp_offset_en ? stamp_sum
                          : a.cycle_stamp_counter;
        end
      end
      op_status_word_store_instr: begin
        case (dif.req.size)
          dest_16: dif.resp.result = {dif.req.operand[63:`HIGH_KEEP_LSB],
                                      cr0_view[`LOW16_MSB:0]};
          dest_32: dif.resp.result = {32'h0000_0000, cr0_view};
          default: dif.resp.result = {32'h0000_0000, cr0_view};
        endcase
      end
      default: dif.resp.result = '0;
    endcase
  end

endmodule : instr_decider

/* src/guest_instruction_virtualization.sv */
// Guest instruction virtualization: control fields, shadows and outcomes
//
// Overview of operation
// - Unowned flag clear clears task switched flag
// - Unowned flag fixed to one: clear instruction faults
// - Owned, shadow zero: clear completes, flag kept
// - Owned, shadow one: clear instruction exits
// - No NMI exiting: return unblocks NMIs
// - NMI exiting: return leaves NMI blocking
// - Status load keeps owned bits, faults unsupported
// - Primary read mixes real and shadow bits
// - Extension read mixes real and shadow bits
// - Priority read uses shadow byte bits 7:4
// - Priority store exiting makes reads exit
// - Primary write keeps owned bits, faults unsupported
// - Extension write keeps owned bits, faults unsupported
// - Priority write stores shadow byte bits 7:4
// - Shadow below threshold raises trap exit
// - Priority load exiting makes writes exit
// - Stamp model read returns raw counter
// - Stamp model read adds signed offset
// - Stamp read returns counter plus offset
// - Stamp read exiting makes stamp read exit
// - Status store mixes real and shadow bits
// - Sixteen bit store keeps destination upper bits
// - Thirty two bit store clears upper half
//
// Implementation choices: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
`include "guest_virt_map.svh"
module guest_instruction_virtualization
  import guest_virt_pkg::*;
(
  // Clock and reset
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  // Wishbone slave
  input  wire logic          cyc_i,
  input  wire logic          stb_i,
  input  wire logic          we_i,
  input  wire logic [7:0]    adr_i,
  input  wire logic [3:0]    sel_i,
  input  wire logic [31:0]   dat_i,
  output logic      [31:0]   dat_o,
  output logic               ack_o,
  // Guest instruction request
  input  wire logic          instr_valid_i,
  input  wire instr_op_type  instr_op_i,
  input  wire logic [63:0]   instr_operand_i,
  input  wire dest_size_type instr_size_i,
  input  wire logic [31:0]   instr_index_i,
  // Interrupt delivery
  input  wire logic          nmi_block_set_i,
  // Instruction outcome
  output logic               done_o,
  output logic               exit_o,
  output logic               fault_o,
  output logic               trap_exit_o,
  output logic [63:0]        result_o,
  output logic               nmi_blocked_o
);

  top_state_type s;
  top_state_type next_s;
  decide_if      dif ();
  logic [31:0]   rd_val;
  logic [31:0]   wr_word;
  logic          bus_req;

  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
      input logic [31:0] new_v, input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    lane_merge = r;
  endfunction : lane_merge

  function automatic logic [31:0] reg_view(input logic [7:0] adr,
      input top_state_type st);
    case (adr)
      `OFF_CTRL:         reg_view = {26'h0, st.cfg.ctrl};
      `OFF_CR0_MASK:     reg_view = st.cfg.cr0_mask;
      `OFF_CR0_SHADOW:   reg_view = st.cfg.cr0_shadow;
      `OFF_CR4_MASK:     reg_view = st.cfg.cr4_mask;
      `OFF_CR4_SHADOW:   reg_view = st.cfg.cr4_shadow;
      `OFF_OFFSET_LO:    reg_view = st.cfg.stamp_offset[31:0];
      `OFF_OFFSET_HI:    reg_view = st.cfg.stamp_offset[63:32];
      `OFF_THRESHOLD:    reg_view = {28'h0, st.cfg.threshold};
      `OFF_CR0_FIXED1:   reg_view = st.cfg.cr0_fixed1;
      `OFF_CR0_ALLOWED1: reg_view = st.cfg.cr0_allowed1;
      `OFF_CR4_FIXED1:   reg_view = st.cfg.cr4_fixed1;
      `OFF_CR4_ALLOWED1: reg_view = st.cfg.cr4_allowed1;
      `OFF_CR0:          reg_view = st.arch.primary_control_reg;
      `OFF_CR4:          reg_view = st.arch.extension_control_reg;
      `OFF_TPR_BYTE:     reg_view = {24'h0, st.arch.tpr_byte};
      `OFF_STATUS:       reg_view = {31'h0, st.nmi_blocked};
      `OFF_COUNT_LO:     reg_view = st.arch.cycle_stamp_counter[31:0];
      `OFF_COUNT_HI:     reg_view = st.arch.cycle_stamp_counter[63:32];
      `OFF_TPR:          reg_view = {28'h0, st.arch.task_priority_value};
      default:           reg_view = 32'h0000_0000;
    endcase
  endfunction : reg_view

  assign dif.req  = '{valid: instr_valid_i, op: instr_op_i,
                      operand: instr_operand_i, size: instr_size_i,
                      index: instr_index_i};
  assign dif.cfg  = s.cfg;
  assign dif.arch = s.arch;

  instr_decider u_decider (
    .dif (dif.decider)
  );

  always_comb begin
    next_s  = s;
    bus_req = cyc_i && stb_i;
    rd_val  = reg_view(adr_i, s);
    wr_word = lane_merge(rd_val, dat_i, sel_i);
    // One wait cycle; ack drops the cycle after it is given
    next_s.ack = bus_req && !s.ack;
    if (bus_req && !s.ack) begin
      next_s.rdata = rd_val;
    end
    next_s.arch.cycle_stamp_counter = s.arch.cycle_stamp_counter +
                                      `COUNT_STEP;
    // Writes commit on the edge where the master samples ack
    if (bus_req && s.ack && we_i) begin
      case (adr_i)
        `OFF_CTRL:         next_s.cfg.ctrl = ctrl_type'(wr_word[5:0]);
        `OFF_CR0_MASK:     next_s.cfg.cr0_mask = wr_word;
        `OFF_CR0_SHADOW:   next_s.cfg.cr0_shadow = wr_word;
        `OFF_CR4_MASK:     next_s.cfg.cr4_mask = wr_word;
        `OFF_CR4_SHADOW:   next_s.cfg.cr4_shadow = wr_word;
        `OFF_OFFSET_LO:    next_s.cfg.stamp_offset[31:0] = wr_word;
        `OFF_OFFSET_HI:    next_s.cfg.stamp_offset[63:32] = wr_word;
        `OFF_THRESHOLD:    next_s.cfg.threshold = wr_word[3:0];
        `OFF_CR0_FIXED1:   next_s.cfg.cr0_fixed1 = wr_word;
        `OFF_CR0_ALLOWED1: next_s.cfg.cr0_allowed1 = wr_word;
        `OFF_CR4_FIXED1:   next_s.cfg.cr4_fixed1 = wr_word;
        `OFF_CR4_ALLOWED1: next_s.cfg.cr4_allowed1 = wr_word;
        `OFF_CR0:          next_s.arch.primary_control_reg = wr_word;
        `OFF_CR4:          next_s.arch.extension_control_reg = wr_word;
        `OFF_TPR_BYTE:     next_s.arch.tpr_byte = wr_word[7:0];
        `OFF_TPR:          next_s.arch.task_priority_value = wr_word[3:0];
        default:           next_s.rdata = s.rdata;
      endcase
    end
    // A guest instruction in the same cycle overrides a bus write to
    // architectural state; the hypervisor is not expected to race it
    next_s.done  = instr_valid_i;
    next_s.exit  = instr_valid_i && dif.resp.exit;
    next_s.fault = instr_valid_i && dif.resp.fault;
    next_s.trap  = instr_valid_i && dif.resp.trap;
    if (instr_valid_i) begin
      next_s.result = dif.resp.result;
      next_s.arch.primary_control_reg =
        dif.resp.arch.primary_control_reg;
      next_s.arch.extension_control_reg =
        dif.resp.arch.extension_control_reg;
      next_s.arch.task_priority_value =
        dif.resp.arch.task_priority_value;
      next_s.arch.tpr_byte = dif.resp.arch.tpr_byte;
      if (dif.resp.nmi_unblock) begin
        next_s.nmi_blocked = 1'b0;
      end
    end
    // A new NMI block in the same cycle wins over the unblock
    if (nmi_block_set_i) begin
      next_s.nmi_blocked = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
      s.cfg.cr0_allowed1 <= `ALLOWED1_RESET;
      s.cfg.cr4_allowed1 <= `ALLOWED1_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign ack_o         = s.ack;
  assign dat_o         = s.rdata;
  assign done_o        = s.done;
  assign exit_o        = s.exit;
  assign fault_o       = s.fault;
  assign trap_exit_o   = s.trap;
  assign result_o      = s.result;
  assign nmi_blocked_o = s.nmi_blocked;

  a_task_flag_clear_instr_normal: assert property (
    @(posedge clk_i) disable iff (rst_i)
    instr_valid_i && instr_op_i == op_task_flag_clear_instr &&
    !s.cfg.cr0_mask[`TS_BIT] && !s.cfg.cr0_fixed1[`TS_BIT]
    |=> done_o && !exit_o && !fault_o &&
        !s.arch.primary_control_reg[`TS_BIT])
    else $error("flag clear did not clear the task switched flag");

  a_task_flag_clear_instr_fault: assert property (
    @(posedge clk_i) disable iff (rst_i)
    instr_valid_i && instr_op_i == op_task_flag_clear_instr &&
    !s.cfg.cr0_mask[`TS_BIT] && s.cfg.cr0_fixed1[`TS_BIT]
    |=> fault_o && !exit_o && $stable(s.arch.primary_control_reg))
    else $error("flag clear with fixed flag did not fault");

  a_task_flag_clear_instr_keep: assert property (
    @(posedge clk_i) disable iff (rst_i)
    instr_valid_i && instr_op_i == op_task_flag_clear_instr &&
    s.cfg.cr0_mask[`TS_BIT] && !s.cfg.cr0_shadow[`TS_BIT]
    |=> !exit_o && !fault_o &&
        s.arch.primary_control_reg[`TS_BIT] ==
        $past(s.arch.primary_control_reg[`TS_BIT]))
    else $error("owned flag clear changed the flag");

  a_task_flag_clear_instr_exit: assert property (
    @(posedge clk_i) disable iff (rst_i)
    instr_valid_i && instr_op_i == op_task_flag_clear_instr &&
    s.cfg.cr0_mask[`TS_BIT] && s.cfg.cr0_shadow[`TS_BIT]
    |=> done_o && exit_o && !fault_o && !trap_exit_o)
    else $error("flag clear with shadow set did not exit");

  a_interrupt_return_instr_unblock: assert property (
    @(posedge clk_i) disable iff (rst_i)
    instr_valid_i && instr_op_i == op_interrupt_return_instr &&
    !s.cfg.ctrl.nmi_exit && !nmi_block_set_i
    |=> !nmi_blocked_o)
    else $error("interrupt return did not unblock NMIs");

  a_interrupt_return_instr_hold: assert property (
    @(posedge clk_i) disable iff (rst_i)
    instr_valid_i && instr_op_i == op_interrupt_return_instr &&
    s.cfg.ctrl.nmi_exit && !nmi_block_set_i
    |=> $stable(nmi_blocked_o))
    else $error("interrupt return changed NMI blocking");

  a_cr0_view: assert property (
    @(posedge clk_i) disable iff (rst_i)
    instr_valid_i && instr_op_i == op_read_primary
    |=> result_o[31:0] ==
        (($past(s.arch.primary_control_reg) & ~$past(s.cfg.cr0_mask)) |
         ($past(s.cfg.cr0_shadow) & $past(s.cfg.cr0_mask))))
    else $error("primary read did not mix real and shadow bits");

  a_prio_read: assert property (
    @(posedge clk_i) disable iff (rst_i)
    instr_valid_i && instr_op_i == op_read_priority &&
    !s.cfg.ctrl.priority_store_exit && s.cfg.ctrl.tpr_shadow_en
    |=> !exit_o && result_o == {60'h0, $past(s.arch.tpr_byte[7:4])})
    else $error("shadowed priority read returned wrong bits");

  a_prio_exit: assert property (
    @(posedge clk_i) disable iff (rst_i)
    instr_valid_i && instr_op_i == op_read_priority &&
    s.cfg.ctrl.priority_store_exit
    |=> exit_o && $stable(s.arch.tpr_byte))
    else $error("priority read did not exit");

  a_prio_trap: assert property (
    @(posedge clk_i) disable iff (rst_i)
    instr_valid_i && instr_op_i == op_write_priority &&
    !s.cfg.ctrl.priority_load_exit && s.cfg.ctrl.tpr_shadow_en
    |=> s.arch.tpr_byte[7:4] == $past(instr_operand_i[3:0]) &&
        trap_exit_o == (s.arch.tpr_byte[7:4] < $past(s.cfg.threshold)))
    else $error("shadowed priority write or trap exit wrong");

  a_stamp_exit: assert property (
    @(posedge clk_i) disable iff (rst_i)
    instr_valid_i && instr_op_i == op_stamp_read_instr &&
    s.cfg.ctrl.stamp_read_exit
    |=> exit_o && done_o)
    else $error("stamp read did not exit");

  a_status_word_store_instr_32: assert property (
    @(posedge clk_i) disable iff (rst_i)
    instr_valid_i && instr_op_i == op_status_word_store_instr &&
    instr_size_i == dest_32
    |=> result_o[63:32] == 32'h0000_0000)
    else $error("32-bit status store left upper half set");

  a_bus_ack: assert property (
    @(posedge clk_i) disable iff (rst_i)
    cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
    else $error("bus ack not a single cycle answer");

  c_task_flag_clear_instr_exit: cover property (
    @(posedge clk_i) disable iff (rst_i)
    exit_o && $past(instr_op_i) == op_task_flag_clear_instr);

  c_prio_trap: cover property (
    @(posedge clk_i) disable iff (rst_i) trap_exit_o);

  c_stamp_offset: cover property (
    @(posedge clk_i) disable iff (rst_i)
    instr_valid_i && instr_op_i == op_stamp_read_instr &&
    s.cfg.ctrl.stamp_offset_en ##1 done_o && !exit_o);

  c_bus_write: cover property (
    @(posedge clk_i) disable iff (rst_i) ack_o && we_i);

endmodule : guest_instruction_virtualization

/* test/guest_pipe_model.sv */
// Guest pipeline model: turns one bench request into one issue pulse
`timescale 1ns/1ps
module guest_pipe_model
  import guest_virt_pkg::*;
(
  // Clock and request from the bench
  input  wire logic    clk_i,
  input  wire logic    go_i,
  input  wire req_type req_i,
  // Issue to the block
  output req_type      req_o
);
  // Idle operand toggles so a held value is never mistaken for a live one
  always_ff @(posedge clk_i) begin
    req_o <= go_i ? req_i
                  : {1'b0, req_o.op, ~req_o.operand, req_o.size, req_o.index};
  end
endmodule : guest_pipe_model

/* test/guest_instruction_virtualization_tb.sv */
// Self-checking bench for the guest instruction virtualization block
`timescale 1ns/1ps
module guest_instruction_virtualization_tb
  import guest_virt_pkg::*;
;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, go;
  logic        nmi_block_set_i, done_o, exit_o, fault_o, trap_exit_o;
  logic        nmi_blocked_o;
  logic [7:0]  adr_i;
  logic [31:0] dat_i, dat_o;
  logic [63:0] result_o, r0, r1, r2;
  req_type     rq, pr;
  int          n_fail, cmp_count;

  guest_instruction_virtualization uut (
    .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i(4'hF),
    .dat_i, .dat_o, .ack_o, .instr_valid_i(pr.valid), .instr_op_i(pr.op),
    .instr_operand_i(pr.operand), .instr_size_i(pr.size),
    .instr_index_i(pr.index), .nmi_block_set_i, .done_o, .exit_o,
    .fault_o, .trap_exit_o, .result_o, .nmi_blocked_o);
  guest_pipe_model far (.clk_i, .go_i(go), .req_i(rq), .req_o(pr));

  task automatic summarize();
    $display("compares %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize

  task automatic chk(input logic [63:0] s, input logic [63:0] e);
    cmp_count++;
    if (s !== e) begin
      n_fail++;
      $display("wrong value at %0t: got %h, want %h", $time, s, e);
    end
  endtask : chk

  // Bounded wait on ack (b=0) or done (b=1)
  task automatic hold(input bit b);
    repeat (40) begin
      @(posedge clk_i);
      if ((b ? done_o : ack_o) === 1'b1) return;
    end
    n_fail++;
    summarize();
  endtask : hold

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    hold(1'b0);
    r0[31:0] = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask : bus

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(r0[31:0], e);
  endtask : rd

  // Outcome flags are packed as exit, fault, trap
  task automatic ins(input instr_op_type o, input logic [63:0] v,
                     input logic [2:0] f, input dest_size_type z = dest_64);
    @(posedge clk_i);
    go <= 1'b1;
    rq <= '{1'b1, o, v, z, 32'h0000_0010};
    @(posedge clk_i);
    go <= 1'b0;
    hold(1'b1);
    chk(64'({exit_o, fault_o, trap_exit_o}), 64'(f));
  endtask : ins

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  initial begin
    instr_op_type op;
    {rst_i, cyc_i, stb_i, we_i, go, nmi_block_set_i} = 6'h20;
    {adr_i, dat_i, rq, n_fail, cmp_count} = '0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'h24, 32'hFFFF_FFFF);
    bus(1'b1, 8'h08, 32'h8);
    bus(1'b1, 8'h30, 32'h8);
    ins(op_task_flag_clear_instr, 64'h0, 3'h0);
    rd(8'h30, 32'h0);
    bus(1'b1, 8'h30, 32'h8);
    bus(1'b1, 8'h20, 32'h8);
    ins(op_task_flag_clear_instr, 64'h0, 3'h2);
    bus(1'b1, 8'h20, 32'h0);
    bus(1'b1, 8'h04, 32'h8);
    bus(1'b1, 8'h08, 32'h0);
    ins(op_task_flag_clear_instr, 64'h0, 3'h0);
    rd(8'h30, 32'h8);
    bus(1'b1, 8'h08, 32'h8);
    ins(op_task_flag_clear_instr, 64'h0, 3'h4);
    bus(1'b1, 8'h04, 32'h00FF_FF00);
    bus(1'b1, 8'h08, 32'h1234_5678);
    bus(1'b1, 8'h30, 32'h0000_0F0F);
    ins(op_read_primary, 64'h0, 3'h0);
    chk(result_o, 64'h0034_560F);
    ins(op_status_word_store_instr, 64'hAAAA_BBBB_CCCC_DDDD, 3'h0, dest_16);
    chk(result_o, 64'hAAAA_BBBB_CCCC_560F);
    ins(op_status_word_store_instr, 64'hAAAA_BBBB_CCCC_DDDD, 3'h0, dest_32);
    chk(result_o, 64'h0034_560F);
    ins(op_status_word_store_instr, 64'hAAAA_BBBB_CCCC_DDDD, 3'h0);
    chk(result_o, 64'h0034_560F);
    ins(op_write_primary, 64'h0034_56F1, 3'h0);
    rd(8'h30, 32'h0000_0FF1);
    bus(1'b1, 8'h24, 32'hFFFF_FFFE);
    ins(op_write_primary, 64'h0034_5601, 3'h2);
    bus(1'b1, 8'h24, 32'hFFFF_FFFF);
    bus(1'b1, 8'h04, 32'h8);
    ins(op_status_word_load_instr, 64'hF, 3'h0);
    rd(8'h30, 32'h0000_0FF7);
    bus(1'b1, 8'h0C, 32'hFFFF_0000);
    bus(1'b1, 8'h10, 32'hABCD_1234);
    bus(1'b1, 8'h34, 32'h0000_5678);
    ins(op_read_extension, 64'h0, 3'h0);
    chk(result_o, 64'hABCD_5678);
    ins(op_write_extension, 64'hABCD_9999, 3'h0);
    rd(8'h34, 32'h0000_9999);
    bus(1'b1, 8'h2C, 32'hFFFF_FFFE);
    ins(op_write_extension, 64'hABCD_0001, 3'h2);
    bus(1'b1, 8'h00, 32'h1);
    @(posedge clk_i) nmi_block_set_i <= 1'b1;
    @(posedge clk_i) nmi_block_set_i <= 1'b0;
    ins(op_interrupt_return_instr, 64'h0, 3'h0);
    chk(nmi_blocked_o, 1'b1);
    bus(1'b1, 8'h00, 32'h0);
    ins(op_interrupt_return_instr, 64'h0, 3'h0);
    chk(nmi_blocked_o, 1'b0);
    bus(1'b1, 8'h1C, 32'h6);
    bus(1'b1, 8'h00, 32'h8);
    ins(op_write_priority, 64'h5, 3'h1);
    rd(8'h38, 32'h50);
    ins(op_read_priority, 64'h0, 3'h0);
    chk(result_o, 64'h5);
    bus(1'b1, 8'h00, 32'hA);
    ins(op_read_priority, 64'h0, 3'h4);
    bus(1'b1, 8'h00, 32'hC);
    ins(op_write_priority, 64'h9, 3'h4);
    bus(1'b1, 8'h00, 32'h0);
    ins(op_write_priority, 64'h9, 3'h0);
    rd(8'h48, 32'h9);
    ins(op_read_priority, 64'h0, 3'h0);
    chk(result_o, 64'h9);
    // Counter runs freely, so offset is judged from evenly spaced reads
    bus(1'b1, 8'h14, 32'hFFFF_F000);
    bus(1'b1, 8'h18, 32'hFFFF_FFFF);
    for (int k = 0; k < 2; k++) begin
      op = k ? op_stamp_read_instr : op_model_reg_read_instr;
      bus(1'b1, 8'h00, 32'h0);
      ins(op, 64'h0, 3'h0);
      r1 = result_o;
      bus(1'b1, 8'h00, 32'h20);
      ins(op, 64'h0, 3'h0);
      r2 = result_o;
      bus(1'b1, 8'h00, 32'h0);
      ins(op, 64'h0, 3'h0);
      chk(r2 - r1 - ((result_o - r1) >> 1), 64'hFFFF_FFFF_FFFF_F000);
    end
    bus(1'b1, 8'h00, 32'h10);
    ins(op_stamp_read_instr, 64'h0, 3'h4);
    summarize();
  end
endmodule : guest_instruction_virtualization_tb
